/* verilog/cdps_pkg.sv */
// Package for the channel discovery and power status block
package cdps_pkg;
  // ****************************************
  // Command codes and layout
  // ****************************************
  localparam logic [7:0] CMD_CH4_DISCOVERY = 8'h0f;
  localparam logic [7:0] CMD_POWER_STATE = 8'h10;
  localparam logic [7:0] RST_CH4_DISCOVERY = 8'h00;
  localparam logic [7:0] RST_POWER_STATE = 8'h00;
  localparam int CLASS_LSB = 4;
  localparam int DETECT_LSB = 0;
  localparam int PG_LSB = 4;
  localparam int ON_LSB = 0;
  localparam int NUM_CH = 4;

  // ****************************************
  // Requested class codes
  // ****************************************
  localparam logic [3:0] RCLS_UNKNOWN = 4'h0;
  localparam logic [3:0] RCLS_RSVD_C0 = 4'h5;
  localparam logic [3:0] RCLS_CLASS0 = 4'h6;
  localparam logic [3:0] RCLS_OVERCUR = 4'h7;
  localparam logic [3:0] RCLS_4P_SS_BASE = 4'h8;
  localparam logic [3:0] RCLS_4PLUS_T1 = 4'hc;
  localparam logic [3:0] RCLS_5_DUAL = 4'hd;
  localparam logic [3:0] RCLS_RSVD_E = 4'he;
  localparam logic [3:0] RCLS_MISMATCH = 4'hf;
  localparam logic [3:0] ASSIGNED_FOR_CLASS0 = 4'h3;

  // ****************************************
  // Detection codes
  // ****************************************
  localparam logic [3:0] DET_UNKNOWN = 4'h0;
  localparam logic [3:0] DET_SHORT = 4'h1;
  localparam logic [3:0] DET_TOO_LOW = 4'h3;
  localparam logic [3:0] DET_VALID = 4'h4;
  localparam logic [3:0] DET_TOO_HIGH = 4'h5;
  localparam logic [3:0] DET_OPEN = 4'h6;
  localparam logic [3:0] DET_FET_FAULT = 4'he;

  // Outcome of one discovery cycle on channel 4, from the core
  typedef struct packed {
    logic valid;            // One-cycle pulse
    logic [3:0] class_num;  // Measured class 0..8 (three-finger)
    logic class_ovc;        // Overcurrent during classification
    logic class_mismatch;   // Fingers disagreed
    logic dual_sig;         // Four-pair dual signature seen
    logic [3:0] det_code;   // Detection status code
  } cdps_disc_s;

  // Register read answer
  typedef struct packed {
    logic ack;
    logic hit;
    logic [7:0] data;
  } cdps_rd_s;
endpackage

/* verilog/cdps_status_regs.sv */
// Channel 4 discovery and four-channel power status registers
// Operation
// - Registers read-only; command 0Fh gives channel 4 discovery, 10h power status.
// - Discovery byte: requested class high nibble, detection low nibble, reset zero.
// - Both discovery fields clear when channel 4 is switched off, unless a new result arrives in that cycle.
// - Class codes 0 unknown, 1-4 classes, 5 reserved, 6 class 0, 7 overcurrent.
// - Codes 8-11 classes 5-8 single signature, 12 limited, 13 dual, 15 mismatch.
// - Requested class is the measured one, kept apart from assigned class.
// - Class 4 or higher under lowest allocation reports class 4+ type-1 limited.
// - A class 0 signature gets assigned class 3 when powered.
// - Three-finger result lets four-pair classes 5 and up be reported.
// - Power status: on flags bits 3-0, power-good bits 7-4, reset zero.
// - Power-good set only when on and drain fell below threshold at turn-on.
// - Power-good latched at turn-on end; cleared only by off or reset.
// - A channel's status flags clear whenever it turns off, faults included.
`timescale 1ns/1ps
module cdps_status_regs #(
  parameter int NCH = cdps_pkg::NUM_CH
) (
  input wire logic mclk,                           // Core clock, 100 MHz
  input wire logic reset_n,                        // Synchronous reset, active low
  input wire logic [NCH-1:0] ch_on,                // Channel switched on, core level
  input wire logic [NCH-1:0] turn_on_done,         // Turn-on finished, one-cycle pulse
  input wire logic [NCH-1:0] channel_drain_sense,  // Drain below power-good threshold, pin
  input wire cdps_pkg::cdps_disc_s disc_in,        // Channel 4 discovery outcome
  input wire logic alloc_lowest,                   // Allocation set to lowest full setting
  input wire logic rd_req,                         // Read request pulse
  input wire logic [7:0] rd_cmd,                   // Command code
  output cdps_pkg::cdps_rd_s rd_out,               // Read answer, one cycle later
  output logic [3:0] assigned_class                // Channel 4 assigned class
);
  // ****************************************
  // Local constants and state
  // ****************************************
  // Channel 4 sits on the top bit; only it has a discovery register here
  localparam int DISC_CH = NCH - 1;

  // Synchroniser and edge stages
  logic [NCH-1:0] drain_meta_r;
  logic [NCH-1:0] drain_sync_r;
  logic [NCH-1:0] ch_on_r;
  // Status registers and their next values
  logic [NCH-1:0] power_good_flags_r;
  wire [NCH-1:0] power_good_flags_nxt;
  logic [3:0] requested_class_field_r;
  logic [3:0] requested_class_field_nxt;
  logic [3:0] detection_result_field_r;
  logic [3:0] detection_result_field_nxt;
  logic [3:0] assigned_r;
  logic [3:0] assigned_nxt;
  // Read answer
  cdps_pkg::cdps_rd_s rd_r;
  cdps_pkg::cdps_rd_s rd_nxt;

  // ****************************************
  // Input synchronisers and edges
  // ****************************************
  // Drain sense comes from pins, so two stages before any logic reads it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      drain_meta_r <= '0;
      drain_sync_r <= '0;
    end else begin
      drain_meta_r <= channel_drain_sense;
      drain_sync_r <= drain_meta_r;
    end
  end

  // Channel state is core logic on this clock; one stage for edges and on flags
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ch_on_r <= cdps_pkg::RST_POWER_STATE[cdps_pkg::ON_LSB +: NCH];
    end else begin
      ch_on_r <= ch_on;
    end
  end

  // Channel 4 edges, taken against the delayed copy
  wire ch4_off_evt = ch_on_r[DISC_CH] && !ch_on[DISC_CH];
  wire ch4_on_evt = !ch_on_r[DISC_CH] && ch_on[DISC_CH];

  // ****************************************
  // Requested class encoding
  // ****************************************
  // Measured class bins; above eight is nothing the core can measure
  wire [3:0] cls = disc_in.class_num;
  wire cls_zero = cls == 4'h0;
  wire cls_two_pair = (cls != 4'h0) && (cls <= 4'h4);
  wire cls_four_pair = (cls >= 4'h5) && (cls <= 4'h8);
  wire cls_hi = cls >= 4'h4;

  // Classes above 4 only arise from the third finger, hence four-pair codes
  wire [3:0] ss_code = cdps_pkg::RCLS_4P_SS_BASE + (cls - 4'h5);
  wire [3:0] base_code = cls_zero ? cdps_pkg::RCLS_CLASS0 :
                         cls_two_pair ? cls :
                         cls_four_pair ? ss_code : cdps_pkg::RCLS_UNKNOWN;

  // Qualifiers in priority order; a mismatch hides every other outcome
  wire use_mismatch = disc_in.class_mismatch;
  wire use_overcur = !use_mismatch && disc_in.class_ovc;
  wire use_limited = !use_mismatch && !use_overcur && alloc_lowest && cls_hi;
  wire use_dual = !use_mismatch && !use_overcur && !use_limited &&
                  disc_in.dual_sig && (cls == 4'h5);
  wire [3:0] class_code = use_mismatch ? cdps_pkg::RCLS_MISMATCH :
                          use_overcur ? cdps_pkg::RCLS_OVERCUR :
                          use_limited ? cdps_pkg::RCLS_4PLUS_T1 :
                          use_dual ? cdps_pkg::RCLS_5_DUAL :
                          base_code;

  // Reserved detection codes pass through as the core reports them
  wire [3:0] det_code = disc_in.det_code;

  // ****************************************
  // Discovery fields of channel 4
  // ****************************************
  // A new result wins over a same-cycle turn-off clear, so no outcome is lost
  assign requested_class_field_nxt = disc_in.valid ? class_code :
                                     ch4_off_evt ? 4'h0 :
                                     requested_class_field_r;
  assign detection_result_field_nxt = disc_in.valid ? det_code :
                                      ch4_off_evt ? 4'h0 :
                                      detection_result_field_r;

  // Both fields start from the register's reset value
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      requested_class_field_r <= cdps_pkg::RST_CH4_DISCOVERY[cdps_pkg::CLASS_LSB +: 4];
      detection_result_field_r <= cdps_pkg::RST_CH4_DISCOVERY[cdps_pkg::DETECT_LSB +: 4];
    end else begin
      requested_class_field_r <= requested_class_field_nxt;
      detection_result_field_r <= detection_result_field_nxt;
    end
  end

  // ****************************************
  // Assigned class, kept apart
  // ****************************************
  // Class 0 signatures, and the reserved code read as class 0, power as class 3
  wire class0_sig = (requested_class_field_r == cdps_pkg::RCLS_CLASS0) ||
                    (requested_class_field_r == cdps_pkg::RCLS_RSVD_C0);
  wire [3:0] assigned_at_on = class0_sig ? cdps_pkg::ASSIGNED_FOR_CLASS0 :
                              requested_class_field_r;
  // Taken at power-up, so it never changes under a powered load
  assign assigned_nxt = ch4_on_evt ? assigned_at_on :
                        ch4_off_evt ? 4'h0 :
                        assigned_r;

  // Limitation: other loads keep their requested code as the assigned class
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      assigned_r <= '0;
    end else begin
      assigned_r <= assigned_nxt;
    end
  end
  assign assigned_class = assigned_r;

  // ****************************************
  // Power-good latches, one per channel
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_pg
      // Drain level judged at the turn-on pulse, through the synchroniser
      wire pg_set = ch_on[g] && turn_on_done[g] && drain_sync_r[g];
      // Any off cycle clears, faults included; set wins a same-cycle clash
      wire pg_clr = !ch_on[g];
      assign power_good_flags_nxt[g] = pg_set ? 1'b1 :
                                       pg_clr ? 1'b0 :
                                       power_good_flags_r[g];
    end
  endgenerate

  // Latches cleared only by turn-off or reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      power_good_flags_r <= cdps_pkg::RST_POWER_STATE[cdps_pkg::PG_LSB +: NCH];
    end else begin
      power_good_flags_r <= power_good_flags_nxt;
    end
  end

  // ****************************************
  // Command-coded read port
  // ****************************************
  // Only these two codes hit here; any other code is still answered, reading zero with hit low
  wire hit_disc = rd_cmd == cdps_pkg::CMD_CH4_DISCOVERY;
  wire hit_pwr = rd_cmd == cdps_pkg::CMD_POWER_STATE;

  // ****************************************
  // Status bytes
  // ****************************************
  // Bytes assembled from the package's field positions
  wire [7:0] disc_byte;
  wire [7:0] pwr_byte;
  assign disc_byte[cdps_pkg::CLASS_LSB +: 4] = requested_class_field_r;
  assign disc_byte[cdps_pkg::DETECT_LSB +: 4] = detection_result_field_r;
  // On flags are the registered channel state, cleared with the channel
  assign pwr_byte[cdps_pkg::PG_LSB +: NCH] = power_good_flags_r;
  assign pwr_byte[cdps_pkg::ON_LSB +: NCH] = ch_on_r;

  // Nothing here is writable, so the port only ever selects a byte
  wire [7:0] rd_sel = hit_disc ? disc_byte : hit_pwr ? pwr_byte : 8'h00;
  // Idle answers are forced to zero so a stale byte never looks valid
  assign rd_nxt.ack = rd_req;
  assign rd_nxt.hit = rd_req && (hit_disc || hit_pwr);
  assign rd_nxt.data = rd_req ? rd_sel : 8'h00;

  // ****************************************
  // Answer register
  // ****************************************
  // Registered answer; it stands for exactly one cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end
  assign rd_out = rd_r;
endmodule

/* testbench/cdps_status_regs_asserts.sv */
// Checker for the discovery and power status registers
`timescale 1ns/1ps
module cdps_sva #(
  parameter int NCH = 4
) (
  input wire logic mclk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic [NCH-1:0] ch_on, // Channel on
  input wire cdps_pkg::cdps_disc_s disc_in, // Discovery outcome
  input wire logic rd_req, // Read request
  input wire logic [7:0] rd_cmd, // Command code
  input wire cdps_pkg::cdps_rd_s rd_out, // Read answer
  input wire logic [3:0] assigned_class // Assigned class
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Decoded requests
  wire rd_pw = rd_req && rd_cmd == cdps_pkg::CMD_POWER_STATE;
  wire rd_dc = rd_req && rd_cmd == cdps_pkg::CMD_CH4_DISCOVERY;
  // Read handshake
  property p_ack; rd_req |=> rd_out.ack; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_src; rd_out.ack |-> $past(rd_req); endproperty
  a_src: assert property (p_src) else $error("answer without request");
  property p_hit; rd_req |=> rd_out.hit == $past(rd_pw || rd_dc); endproperty
  a_hit: assert property (p_hit) else $error("wrong hit flag");
  property p_quiet; !rd_out.ack |-> rd_out.data == 8'h00 && !rd_out.hit; endproperty
  a_quiet: assert property (p_quiet) else $error("answer bus not idle");
  // Status contents; on flags lag the channel by one cycle
  property p_pe; rd_pw |=> rd_out.data[3:0] == $past(ch_on, 2); endproperty
  a_pe: assert property (p_pe) else $error("on flags wrong");
  property p_pgoff; rd_pw |=> (rd_out.data[7:4] & ~$past(ch_on, 2)) == 4'h0; endproperty
  a_pgoff: assert property (p_pgoff) else $error("power good on an off channel");
  property p_disc; disc_in.valid ##1 rd_dc && !$fell(ch_on[3]) |=> rd_out.data[3:0] == $past(disc_in.det_code, 2);
  endproperty
  a_disc: assert property (p_disc) else $error("detect field wrong");
  property p_mm; disc_in.valid && disc_in.class_mismatch ##1 rd_dc && !$fell(ch_on[3]) |=> rd_out.data[7:4] == 4'hf;
  endproperty
  a_mm: assert property (p_mm) else $error("mismatch code wrong");
  property p_rst; $rose(reset_n) |-> rd_out == '0 && assigned_class == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_asg; !ch_on[3] [*2] |-> assigned_class == 4'h0; endproperty
  a_asg: assert property (p_asg) else $error("assigned class while off");
  // Main scenarios reached
  cover property (rd_pw ##1 rd_out.data[7:4] != 4'h0);
  cover property (rd_req && !rd_pw && !rd_dc);
  cover property (disc_in.valid && disc_in.class_mismatch);
endmodule
bind cdps_status_regs cdps_sva #(.NCH(NCH)) u_sva (.*);

/* testbench/cdps_host.sv */
// Host model issuing one-byte register reads
`timescale 1ns/1ps
module cdps_host (
  input wire logic go, // Read wanted this cycle
  input wire logic [7:0] cmd, // Command to read
  output logic rd_req, // Read request
  output logic [7:0] rd_cmd // Command, scrambled when idle
);
  // Idle code is inverted so a stale command never looks valid
  assign rd_req = go;
  assign rd_cmd = go ? cmd : ~cmd;
endmodule

/* testbench/cdps_status_regs_tb_top.sv */
// Self-checking bench for the status registers
`timescale 1ns/1ps
module cdps_status_regs_tb_top;
  logic mclk = 0, reset_n = 0, alloc_lowest = 0, go = 0, rd_req;
  logic [3:0] ch_on = 0, tod = 0, drain = 0, assigned_class, pg, r;
  logic [7:0] cmd = 0, rd_cmd;
  cdps_pkg::cdps_disc_s disc = '0;
  cdps_pkg::cdps_rd_s rd_out;
  logic [8:0] expq[$];
  int error_cnt = 0, check_count = 0;
  logic [3:0] dets[7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'he};
  always #5 mclk = ~mclk;
  cdps_status_regs uut (.mclk(mclk), .reset_n(reset_n), .ch_on(ch_on), .turn_on_done(tod),
    .channel_drain_sense(drain), .disc_in(disc), .alloc_lowest(alloc_lowest), .rd_req(rd_req),
    .rd_cmd(rd_cmd), .rd_out(rd_out), .assigned_class(assigned_class));
  cdps_host host (.go(go), .cmd(cmd), .rd_req(rd_req), .rd_cmd(rd_cmd));
  // Monitor: each answer is matched with the oldest note
  always @(negedge mclk) begin
    if (rd_out.ack === 1'b1) begin
      check_count++;
      if (expq.size() == 0 || {rd_out.hit, rd_out.data} !== expq[0]) begin
        error_cnt++;
        $display("mismatch t=%0t exp=%h got=%h", $time, expq.size() ? expq[0] : 9'h0, {rd_out.hit, rd_out.data});
      end
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  // Read leaves the request up so reads can run back to back
  task automatic rd(input logic [7:0] c, input logic [8:0] e);
    go = 1;
    cmd = c;
    expq.push_back(e);
    @(negedge mclk);
  endtask
  task automatic idle();
    go = 0;
    @(negedge mclk);
  endtask
  // Direct compare for the level output, outside the read queue
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  function automatic logic [3:0] ecls(input logic [3:0] c, input logic mm, ov, lo, du);
    if (mm) return 4'hf;
    if (ov) return 4'h7;
    if (lo && c >= 4) return 4'hc;
    if (du && c == 5) return 4'hd;
    if (c == 0) return 4'h6;
    return c <= 4 ? c : (c <= 8 ? c + 4'h3 : 4'h0);
  endfunction
  // One discovery outcome, then read it back the next cycle
  task automatic dsc(input logic [3:0] c, input logic mm, ov, lo, du);
    logic [3:0] d;
    d = dets[$urandom % 7];
    alloc_lowest = lo;
    disc = {1'b1, c, ov, mm, du, d};
    @(negedge mclk) disc.valid = 0;
    rd(cdps_pkg::CMD_CH4_DISCOVERY, {1'b1, ecls(c, mm, ov, lo, du), d});
    idle();
  endtask
  task automatic end_sim();
    error_cnt += expq.size(); // Reads never answered count as mismatches
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog, well beyond the 82 cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h8530));
    repeat (3) @(negedge mclk);
    reset_n = 1;
    rd(8'h0f, 9'h100);
    rd(8'h10, 9'h100);
    rd(8'h11, 9'h000);
    idle();
    $display("reset values done");
    for (int i = 0; i <= 8; i++) dsc(i[3:0], 0, 0, 0, 0);
    dsc(4'h4, 1, 0, 0, 0);
    dsc(4'h2, 0, 1, 0, 0);
    dsc(4'h8, 0, 0, 1, 0);
    dsc(4'h3, 0, 0, 1, 0);
    dsc(4'h5, 0, 0, 0, 1);
    dsc(4'h0, 0, 0, 0, 0);
    $display("discovery codes done");
    drain = 4'hb;
    ch_on = 4'hf;
    repeat (3) @(negedge mclk);
    chk(assigned_class, 4'h3);
    tod = 4'hf;
    @(negedge mclk) tod = 0;
    rd(8'h10, 9'h1bf);
    drain = 4'h0;
    idle();
    rd(8'h10, 9'h1bf);
    ch_on = 4'h7;
    idle();
    chk(assigned_class, 4'h0);
    rd(8'h10, 9'h137);
    rd(8'h0f, 9'h100);
    idle();
    pg = 4'h3;
    repeat (4) begin
      r = $urandom;
      ch_on = r;
      pg = pg & r;
      idle();
      rd(8'h10, {1'b1, pg, r});
      idle();
    end
    $display("power status done");
    ch_on = 4'hf;
    reset_n = 0;
    repeat (2) @(negedge mclk);
    reset_n = 1;
    @(negedge mclk);
    rd(8'h10, 9'h10f);
    idle();
    $display("mid-run reset done");
    repeat (2) @(negedge mclk);
    end_sim();
  end
endmodule
